//--- design/smr_pkg.sv
package smr_pkg;

    // ==================================================================
    // Widths of the host port and of the internal storage word
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int WORD_W = 64;
    localparam int CHK_W  = 7;
    localparam int CW_W   = WORD_W + CHK_W;
    localparam int IDX_W  = 18;
    localparam int WORDS  = 262144;

    // ==================================================================
    // Counter limits and values after reset
    localparam logic [ADDR_W-1:0] ADDR_LAST_BYTE = 21'h1FFFFF;
    localparam logic [ADDR_W-1:0] ADDR_LAST_HALF = 21'h0FFFFF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO      = 21'h000000;
    localparam logic [ADDR_W-1:0] ADDR_ONE       = 21'h000001;
    localparam logic [DATA_W-1:0] RDATA_RST      = 16'h0000;

    // ==================================================================
    // Host timing, in ns and in clock cycles at 25 MHz
    localparam int CLK_NS       = 40;
    localparam int RD_CYCLE_NS  = 120;
    localparam int RD_ACCESS_NS = 95;
    localparam int WR_CYCLE_NS  = 140;
    localparam int PWRUP_NS     = 2000000;
    localparam int RD_CYCLE_CYC  = (RD_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WR_CYCLE_CYC  = (WR_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWRUP_CYC     = (PWRUP_NS + CLK_NS - 1) / CLK_NS;

    // ==================================================================
    // Kind of access taken at the last rising edge
    typedef enum logic [3:0] {
        ST_DIS = 4'b0001,
        ST_RD  = 4'b0010,
        ST_WR  = 4'b0100,
        ST_SEQ = 4'b1000
    } smr_state_type;

    // Host request as captured at a rising edge
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              we;
        logic              cs_n;
        logic [DATA_W-1:0] wdata;
    } smr_req_type;

endpackage : smr_pkg

//--- design/smr_ecc.sv
`timescale 1ns/1ps
`default_nettype none

module smr_ecc
    import smr_pkg::*;
(
    // Encode side
    input  wire logic [WORD_W-1:0] enc_data_i,
    output logic      [CHK_W-1:0]  enc_chk_o,
    // Decode side
    input  wire logic [CW_W-1:0]   dec_word_i,
    output logic      [WORD_W-1:0] dec_data_o,
    output logic                   dec_fix_o
);

    // ==================================================================
    // Hamming layout: check bits sit at positions 1,2,4..64 of 71

    // Spread data bits over the non-power-of-two positions
    function automatic logic [CW_W-1:0] place(input logic [WORD_W-1:0] d);
        int j;
        j = 0;
        place = '0;
        for (int p = 1; p <= CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                place[p-1] = d[j];
                j++;
            end
        end
    endfunction : place

    // Gather data bits back from a codeword
    function automatic logic [WORD_W-1:0] gather(input logic [CW_W-1:0] c);
        int j;
        j = 0;
        gather = '0;
        for (int p = 1; p <= CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                gather[j] = c[p-1];
                j++;
            end
        end
    endfunction : gather

    // XOR of the positions of all set bits
    function automatic logic [CHK_W-1:0] syn(input logic [CW_W-1:0] c);
        syn = '0;
        for (int p = 1; p <= CW_W; p++) begin
            if (c[p-1]) begin
                syn = syn ^ CHK_W'(p);
            end
        end
    endfunction : syn

    // ==================================================================
    // Check code of a word to be stored
    always_comb begin
        enc_chk_o = syn(place(enc_data_i));
    end

    // Single-bit correction of a fetched word; no write-back here
    always_comb begin
        logic [CW_W-1:0]  cw;
        logic [CHK_W-1:0] s;
        cw = place(dec_word_i[WORD_W-1:0]);
        s  = '0;
        for (int i = 0; i < CHK_W; i++) begin
            cw[(1 << i) - 1] = dec_word_i[WORD_W + i];
        end
        s = syn(cw);
        dec_fix_o = (s != '0);
        if (s != '0 && int'(s) <= CW_W) begin
            cw[s - CHK_W'(1)] = ~cw[s - CHK_W'(1)];
        end
        dec_data_o = gather(cw);
    end

endmodule : smr_ecc
`default_nettype wire

//--- design/smr_port.sv
`timescale 1ns/1ps
`default_nettype none

module smr_port
    import smr_pkg::*;
#(
    parameter int PWRUP_CYCLES = PWRUP_CYC
)(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Host access pins
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              cs_n_i,
    input  wire logic              we_i,
    input  wire logic              oe_i,
    // Data pins, split into input, output and enable
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_o,
    // Configuration
    input  wire logic              byte_width_strap_i,
    // Sequential read qualifiers and chain
    input  wire logic              sequential_read_select_i,
    input  wire logic              cnt_arm_i,
    input  wire logic              cnt_release_i,
    input  wire logic              carry_in_i,
    output logic                   carry_out_o,
    // Status
    output logic                   ecc_fix_o
);

    // ==================================================================
    // Storage: data word with its check code, never reset
    logic [CW_W-1:0] mem_r [0:WORDS-1];

    smr_req_type       req;
    smr_state_type     state_r, state_nxt;
    logic [ADDR_W-1:0] cnt_r, cnt_nxt, acc_addr, cnt_last;
    logic              carry_r, carry_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic              fix_r, fix_nxt;
    logic              wr_en, rd_en, seq_en, qual_ok;
    logic [CW_W-1:0]   word_rd;
    logic [WORD_W-1:0] word_fix, word_mrg, lane_mask, lane_data;
    logic [CHK_W-1:0]  word_chk;
    logic              word_bad;

    // ==================================================================
    // Address decode helpers

    // Storage word holding a given host address
    function automatic logic [IDX_W-1:0] word_idx(
        input logic [ADDR_W-1:0] a,
        input logic              bytes
    );
        word_idx = bytes ? a[20:3] : a[19:2];
    endfunction : word_idx

    // Bit offset of the addressed lane inside the storage word
    function automatic logic [5:0] lane_sh(
        input logic [ADDR_W-1:0] a,
        input logic              bytes
    );
        lane_sh = bytes ? {a[2:0], 3'h0} : {a[1:0], 4'h0};
    endfunction : lane_sh

    // Addressed lane of a word, upper byte zero in byte mode
    function automatic logic [DATA_W-1:0] lane_get(
        input logic [WORD_W-1:0] w,
        input logic [ADDR_W-1:0] a,
        input logic              bytes
    );
        logic [WORD_W-1:0] s;
        s = w >> lane_sh(a, bytes);
        lane_get = bytes ? {8'h00, s[7:0]} : s[15:0];
    endfunction : lane_get

    // ==================================================================
    // Capture of the host pins at the edge
    always_comb begin
        req = '{addr: addr_i, we: we_i, cs_n: cs_n_i, wdata: dq_i};
    end

    // Last counter address depends on the width strap
    always_comb begin
        cnt_last = byte_width_strap_i ? ADDR_LAST_BYTE
                                      : ADDR_LAST_HALF;
    end

    // ==================================================================
    // Access decode and sequential counter, next values
    always_comb begin
        state_nxt = ST_DIS;
        cnt_nxt   = cnt_r;
        carry_nxt = carry_r;
        wr_en     = 1'b0;
        rd_en     = 1'b0;
        seq_en    = 1'b0;
        acc_addr  = req.addr;
        qual_ok   = cnt_arm_i && !cnt_release_i && carry_in_i;
        if (sequential_read_select_i) begin
            // Write strobe plays no part here: read-only mode
            if (!qual_ok) begin
                cnt_nxt   = ADDR_ZERO;
                carry_nxt = 1'b0;
            end else if (!req.cs_n) begin
                seq_en    = 1'b1;
                state_nxt = ST_SEQ;
                acc_addr  = cnt_r;
                if (cnt_r == cnt_last) begin
                    cnt_nxt   = ADDR_ZERO;
                    carry_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + ADDR_ONE;
                end
            end
        end else if (!req.cs_n) begin
            if (req.we) begin
                wr_en     = 1'b1;
                state_nxt = ST_WR;
            end else begin
                rd_en     = 1'b1;
                state_nxt = ST_RD;
            end
        end
    end

    // ==================================================================
    // Word fetch, correction and merge of the written lane
    always_comb begin
        word_rd   = mem_r[word_idx(acc_addr, byte_width_strap_i)];
        lane_mask = byte_width_strap_i
                  ? (64'h00000000000000FF << lane_sh(acc_addr, 1'b1))
                  : (64'h000000000000FFFF << lane_sh(acc_addr, 1'b0));
        // Upper data lines are ignored in byte mode, not trusted
        lane_data = byte_width_strap_i
                  ? ({56'h0, req.wdata[7:0]} << lane_sh(acc_addr, 1'b1))
                  : ({48'h0, req.wdata} << lane_sh(acc_addr, 1'b0));
        word_mrg  = (word_fix & ~lane_mask) | (lane_data & lane_mask);
    end

    smr_ecc u_ecc (
        .enc_data_i (word_mrg),
        .enc_chk_o  (word_chk),
        .dec_word_i (word_rd),
        .dec_data_o (word_fix),
        .dec_fix_o  (word_bad)
    );

    // Read data and correction flag, next values
    always_comb begin
        rdata_nxt = rdata_r;
        fix_nxt   = 1'b0;
        if (rd_en || seq_en) begin
            rdata_nxt = lane_get(word_fix, acc_addr,
                                 byte_width_strap_i);
            fix_nxt   = word_bad;
        end
    end

    // ==================================================================
    // Storage update; the cells change only on a host write. A partial
    // write must merge the other lanes, so they pass through correction
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem_r[word_idx(acc_addr, byte_width_strap_i)]
                <= {word_chk, word_mrg};
        end
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_DIS;
            cnt_r   <= ADDR_ZERO;
            carry_r <= 1'b0;
            rdata_r <= RDATA_RST;
            fix_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            carry_r <= carry_nxt;
            rdata_r <= rdata_nxt;
            fix_r   <= fix_nxt;
        end
    end

    // ==================================================================
    // Pin drivers; normal reads gate the drive with the clock level,
    // so the pins float for the low half of every normal read cycle
    always_comb begin
        case (state_r)
            ST_RD:   dq_oe_o = clk_i && oe_i;
            ST_SEQ:  dq_oe_o = !cs_n_i;
            ST_WR:   dq_oe_o = 1'b0;
            ST_DIS:  dq_oe_o = 1'b0;
            default: dq_oe_o = 1'b0;
        endcase
    end

    assign dq_o        = rdata_r;
    assign carry_out_o = carry_r;
    assign ecc_fix_o   = fix_r;

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    logic [DATA_W-1:0] wlane;
    assign wlane = byte_width_strap_i ? {8'h00, dq_i[7:0]} : dq_i;

    a_read_capture: assert property (rd_en |=> state_r == ST_RD)
        else $error("read not taken at edge");
    a_deselect_float: assert property (
        !sequential_read_select_i && cs_n_i |=> !dq_oe_o)
        else $error("pins driven while deselected");
    a_write_float: assert property (
        !sequential_read_select_i && !cs_n_i && we_i |=> !dq_oe_o)
        else $error("pins driven after write");
    // Falling edge: at the rising one the clock gate is already shut,
    // so a wrong read drive would never show there
    a_oe_low_float: assert property (@(negedge clk_i)
        state_r == ST_RD |-> dq_oe_o == oe_i)
        else $error("read drive not following output enable");
    a_seq_drive: assert property (
        state_r == ST_SEQ |-> dq_oe_o == !cs_n_i)
        else $error("sequential drive not following select");
    a_seq_no_write: assert property (
        sequential_read_select_i |-> !wr_en)
        else $error("write in sequential mode");
    a_cnt_step: assert property (
        seq_en && cnt_r != cnt_last |=> cnt_r == $past(cnt_r) + ADDR_ONE)
        else $error("counter did not advance by one");
    a_cnt_clear: assert property (
        sequential_read_select_i && !qual_ok
        |=> cnt_r == ADDR_ZERO && !carry_out_o)
        else $error("counter not cleared");
    a_carry_rise: assert property (
        seq_en && cnt_r == cnt_last |=> carry_out_o && cnt_r == ADDR_ZERO)
        else $error("carry out missing at last address");
    a_half_top: assert property (
        !byte_width_strap_i && seq_en && cnt_r == ADDR_LAST_HALF
        |=> cnt_r == ADDR_ZERO)
        else $error("counter wider than halfword space");
    a_byte_upper: assert property (
        byte_width_strap_i && rd_en |=> dq_o[15:8] == 8'h00)
        else $error("upper lines carry data in byte mode");
    // Host write spacing puts the earliest read back four edges later
    a_write_readback: assert property (
        wr_en ##4 (rd_en && addr_i == $past(addr_i, 4))
        |=> dq_o == $past(wlane, 5))
        else $error("read back differs from written data");

    c_write_read: cover property (wr_en ##1 rd_en);
    c_seq_run: cover property (seq_en [*4]);
    c_carry: cover property (seq_en && cnt_r == cnt_last);
    c_ecc_fix: cover property (ecc_fix_o);

endmodule : smr_port
`default_nettype wire

//--- testbench/smr_host.sv
`timescale 1ns/1ps
`default_nettype none

// ====================
// Host controller model: owns the access pins, keeps host spacing
module smr_host
    import smr_pkg::*;
#(
    parameter int START_CYC = 8
)(
    // Clock and device answers
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] rd_data_i,
    input  wire logic              rd_oe_i,
    // Access pins
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   cs_n_o,
    output logic                   we_o,
    output logic                   oe_o,
    output logic      [DATA_W-1:0] wdata_o,
    // Strap and sequential qualifiers
    output logic                   strap_o,
    output logic                   seq_o,
    output logic                   arm_o,
    output logic                   rel_o,
    output logic                   cin_o
);
    logic [DATA_W-1:0] mask;

    // Upper lines grounded in byte mode
    assign mask = strap_o ? 16'h00FF : 16'hFFFF;

    // Idle, deselected pins at time zero
    initial begin
        {strap_o, oe_o, seq_o, arm_o, rel_o, cin_o, cs_n_o, we_o} = 8'h42;
        addr_o  = '0;
        wdata_o = 16'h5A5A;
    end

    // Level pins {strap, oe, seq, arm, release, carry in, cs_n, we}
    task automatic pins(input logic [7:0] v);
        {strap_o, oe_o, seq_o, arm_o, rel_o, cin_o, cs_n_o, we_o} <= v;
    endtask : pins

    // Start-up wait before the first access
    task automatic wait_start();
        repeat (START_CYC) @(posedge clk_i);
    endtask : wait_start

    // One write; released data lines show the inverse afterwards
    task automatic write(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d,
                         input logic cs, output logic drv);
        addr_o  <= strap_o ? a : {1'b0, a[19:0]};
        cs_n_o  <= cs;
        we_o    <= 1'b1;
        wdata_o <= d & mask;
        @(posedge clk_i);
        cs_n_o  <= 1'b1;
        we_o    <= 1'b0;
        wdata_o <= ~d & mask;
        #1 drv = rd_oe_i;
        repeat (3) @(posedge clk_i);
    endtask : write

    // One read; drive seen in clock-high and clock-low halves
    task automatic read(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d,
                        output logic [1:0] drv);
        addr_o <= strap_o ? a : {1'b0, a[19:0]};
        cs_n_o <= 1'b0;
        we_o   <= 1'b0;
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        #1 drv[1] = rd_oe_i;
        #20 drv[0] = rd_oe_i;
        repeat (3) @(posedge clk_i);
        d = rd_data_i;
    endtask : read
endmodule : smr_host

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

// ====================
// Self-checking bench for the memory port
module testbench
    import smr_pkg::*;
;
    localparam logic [7:0] QUAL = 8'h35; // Qualified, oe low, we high

    logic              clk_i     = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic              cs_n, we, oe, strap, seq, arm, rel, cin;
    logic [DATA_W-1:0] wdata, dq_bus, dq_o, rd;
    logic              dq_oe_o, carry_out_o, ecc_fix_o;
    logic [1:0]        drv;
    int                n_mismatch = 0;
    int                cmp_count  = 0;

    // Wire level: device wins only while it drives
    assign dq_bus = dq_oe_o ? dq_o : wdata;

    // Clock at 25 MHz
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    smr_port u_smr_port (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
        .cs_n_i(cs_n), .we_i(we), .oe_i(oe), .dq_i(dq_bus),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .byte_width_strap_i(strap),
        .sequential_read_select_i(seq), .cnt_arm_i(arm),
        .cnt_release_i(rel), .carry_in_i(cin),
        .carry_out_o(carry_out_o), .ecc_fix_o(ecc_fix_o)
    );

    smr_host #(.START_CYC(PWRUP_CYC)) u_smr_host (
        .clk_i(clk_i), .rd_data_i(dq_o), .rd_oe_i(dq_oe_o),
        .addr_o(addr), .cs_n_o(cs_n), .we_o(we), .oe_o(oe),
        .wdata_o(wdata), .strap_o(strap), .seq_o(seq), .arm_o(arm),
        .rel_o(rel), .cin_o(cin)
    );

    // ====================
    // Helpers
    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return {~a[7:0], a[7:0] ^ {a[20], a[19], 6'h2A}};
    endfunction : pat

    task automatic chk(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Reset with the strap settled beforehand
    task automatic do_reset(input logic s);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        u_smr_host.pins({s, 7'h42});
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk(dq_o, RDATA_RST, "reset data");
        chk({13'h0, dq_oe_o, carry_out_o, ecc_fix_o}, 16'h0000, "idle");
    endtask : do_reset

    // ====================
    // Scenarios
    task automatic t_half();
        logic w;
        for (int a = 0; a < 8; a++) begin
            u_smr_host.write(21'(a), pat(21'(a)), 1'b0, w);
            chk({15'h0, w}, 16'h0000, "write drive");
        end
        for (int a = 7; a >= 0; a--) begin
            u_smr_host.read(21'(a), rd, drv);
            chk(rd, pat(21'(a)), "read data");
            chk({14'h0, drv}, 16'h0002, "read drive");
        end
        u_smr_host.pins(8'h02);
        @(posedge clk_i);
        u_smr_host.read(21'h000003, rd, drv);
        chk({14'h0, drv}, 16'h0000, "oe low drive");
        u_smr_host.write(21'h000002, 16'hFFFF, 1'b1, w);
        chk({15'h0, w}, 16'h0000, "deselect drive");
        u_smr_host.read(21'h000002, rd, drv);
        chk(rd, pat(21'h000002), "deselected write");
    endtask : t_half

    // One qualified edge: data in the high half, drive in both clock halves, no carry;
    // the next pin levels go out at that edge, so drive follows select
    task automatic seq_step(input logic [ADDR_W-1:0] a,
                            input logic [7:0]        nxt);
        @(posedge clk_i);
        u_smr_host.pins(nxt);
        #1 chk(dq_o, pat(a), "seq data");
        chk({15'h0, dq_oe_o}, {15'h0, ~nxt[1]}, "seq drive hi");
        #20 chk({15'h0, dq_oe_o}, {15'h0, ~nxt[1]}, "seq drive lo");
        chk({14'h0, carry_out_o, ecc_fix_o}, 16'h0000, "carry");
    endtask : seq_step

    task automatic t_seq();
        u_smr_host.pins(QUAL ^ 8'h10);
        @(posedge clk_i);
        u_smr_host.pins(QUAL);
        for (int k = 0; k < 4; k++) begin
            seq_step(21'(k), (k == 3) ? (QUAL | 8'h02) : QUAL);
        end
        @(posedge clk_i);
        u_smr_host.pins(QUAL);
        #1 chk({15'h0, dq_oe_o}, 16'h0000, "seq deselect");
        seq_step(21'h000004, QUAL ^ 8'h10);
        for (int q = 0; q < 3; q++) begin
            @(posedge clk_i);
            u_smr_host.pins(QUAL);
            #1 chk({15'h0, dq_oe_o}, 16'h0000, "qualifier off");
            seq_step(21'h000000,
                     (q < 2) ? (QUAL ^ (8'h08 >> q)) : 8'h42);
        end
        @(posedge clk_i);
        u_smr_host.read(21'h000000, rd, drv);
        chk(rd, pat(21'h000000), "no write in seq");
    endtask : t_seq

    task automatic t_byte();
        logic              w;
        logic [ADDR_W-1:0] ab;
        for (int a = 0; a < 16; a++) begin
            ab = {a[3], 17'h0, a[2:0]};
            u_smr_host.write(ab, pat(ab), 1'b0, w);
        end
        for (int a = 15; a >= 0; a -= 5) begin
            ab = {a[3], 17'h0, a[2:0]};
            u_smr_host.read(ab, rd, drv);
            chk(rd, pat(ab) & 16'h00FF, "byte data");
        end
    endtask : t_byte

    // ====================
    // Verdict and run control
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Watchdog: start-up wait plus well beyond a few hundred test cycles
    initial begin
        repeat (PWRUP_CYC + 5000) @(posedge clk_i);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    // Main sequence
    initial begin
        do_reset(1'b0);
        u_smr_host.wait_start();
        t_half();
        t_seq();
        do_reset(1'b1);
        t_byte();
        wrap_up();
    end
endmodule : testbench

`default_nettype wire
